// [logic/wwd_top.sv]
// Windowed watchdog with clock monitor, idle timer flag and fault pin
// Operation
// - Window 2k lower, select bits pick upper
// - Monitor passes 10 kHz, rejects 10 Hz
// - Both detectors inactive while reset held
// - Reset arms, maximum window, monitor enabled
// - First keyed write fixes window and monitor
// - Later writes must match all fields
// - Service inside window, else error
// - First write also restarts the window
// - Fault pin active low, else released
// - Hold low 16-32 cycles after pin low
// - Window restarts when pin returns high
// - Services during watchdog fault output are ignored
// - Slow clock drives pin, held after recovery
// - Key field always reads as zero
// - Watchdog stops in halt, monitor runs
// - RC option without delay resumes after halt
// - Otherwise halt exit reloads the window
// - Idle exit performs a hardware service
// - First service accepted anywhere in window
// - Idle flag set each 4096 cycles
`timescale 1ns/1ns
`default_nettype none
module wwd_top #(
  parameter int MON_LIMIT = wwd_pkg::MON_LIMIT_CYC
) (
  input wire logic CLOCK_IN, // 250 MHz system clock
  input wire logic NRST_IN, // Synchronous reset, active low
  input wire logic CE_IN, // Clock enable, freezes all state
  input wire logic TC_TICK_IN, // One pulse per instruction cycle
  input wire logic HALT_IN, // Halt mode
  input wire logic IDLE_IN, // Idle mode
  input wire logic RC_OPTION_IN, // Single-pin RC oscillator option
  input wire logic OSCILLATOR_START_DELAY_IN, // Start-delay bit
  input wire logic PORT_G_BIT_ONE_IN, // Sensed fault pin level
  input wire logic [7:0] ADDR_IN, // Register address
  input wire logic [7:0] WDATA_IN, // Write data
  input wire logic WR_IN, // Write strobe
  input wire logic RD_IN, // Read strobe
  output logic [7:0] RDATA_OUT, // Read data, cycle after strobe
  output logic PORT_G_BIT_ONE_OUT, // Fault pin drive level
  output logic PORT_G_BIT_ONE_OE_OUT, // Fault pin pulled low
  output logic IDLE_TIMER_PENDING_OUT // Idle timer pending flag
);
  import wwd_pkg::*;

  wwd_state_t state, next_state;
  logic [16:0] cnt, next_cnt;
  logic [1:0] win, next_win;
  logic mon, next_mon;
  logic locked, next_locked;
  logic [4:0] hold, next_hold;
  logic halt_q, idle_q;
  logic pend, next_pend;
  logic oe, next_oe;
  logic [7:0] rdata, next_rdata;
  logic [15:0] idle_cnt = '0;
  logic [15:0] next_idle_cnt;
  logic cm_fault;
  logic svc_wr, key_ok, fields_ok, run_tick, halt_exit, idle_exit;
  logic wd_drive;
  logic [16:0] upper;

  function automatic logic [16:0] upper_ticks(input logic [1:0] sel);
    upper_ticks = UPPER_BASE_TICKS << sel;
  endfunction

  // ----------------------------------------------------------------------
  // Clock monitor
  // ----------------------------------------------------------------------
  // gap limit sits between the two rates
  wwd_clock_monitor #(
    .LIMIT_CYC(MON_LIMIT),
    .HOLD(HOLD_TICKS)
  ) u_mon (
    .clock_in(CLOCK_IN),
    .nrst_in(NRST_IN),
    .ce_in(CE_IN),
    .enable_in(mon),
    .tick_in(TC_TICK_IN),
    .fault_out(cm_fault)
  );

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  always_comb begin
    svc_wr = WR_IN && (ADDR_IN == ADDR_SERVICE);
    key_ok = WDATA_IN[KEY_MSB:KEY_LSB] == SERVICE_KEY;
    // compare window, key and monitor select
    fields_ok = key_ok && (WDATA_IN[WIN_MSB:WIN_LSB] == win) &&
                (WDATA_IN[MON_BIT] == mon);
    // watchdog counts only outside halt and idle
    run_tick = TC_TICK_IN && !HALT_IN && !IDLE_IN;
    halt_exit = halt_q && !HALT_IN;
    idle_exit = idle_q && !IDLE_IN;
    upper = upper_ticks(win);
    wd_drive = (state == WS_PULL) || (state == WS_HOLD);
  end

  // ----------------------------------------------------------------------
  // Watchdog sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_win = win;
    next_mon = mon;
    next_locked = locked;
    next_hold = hold;
    case (state)
      WS_INIT, WS_RUN: begin
        if (run_tick) begin
          next_cnt = cnt + 17'h00001;
        end
        // leaving idle counts as a service
        if (idle_exit) begin
          next_cnt = '0;
        end
        // RC without start delay keeps its place
        // other oscillator setups reload on halt exit
        if (halt_exit && !(RC_OPTION_IN && !OSCILLATOR_START_DELAY_IN)) begin
          next_cnt = '0;
        end
        if (svc_wr && state == WS_INIT) begin
          // only a keyed first write sets the choices
          // no lower limit on the first service
          if (key_ok) begin
            next_win = WDATA_IN[WIN_MSB:WIN_LSB];
            next_mon = WDATA_IN[MON_BIT];
            next_locked = 1'b1;
            next_cnt = '0;
            next_state = WS_RUN;
          end else begin
            next_state = WS_PULL;
          end
        end else if (svc_wr) begin
          // early or mismatched service is a fault
          if (!fields_ok || cnt < LOWER_TICKS || cnt >= upper) begin
            next_state = WS_PULL;
          end else begin
            next_cnt = '0;
          end
        end else if (cnt >= upper) begin
          // upper limit follows the select bits
          // no service before the upper limit
          next_state = WS_PULL;
        end
      end
      WS_PULL: begin
        // hold starts once the pin is seen low
        if (!PORT_G_BIT_ONE_IN) begin
          next_hold = '0;
          next_state = WS_HOLD;
        end
      end
      WS_HOLD: begin
        if (hold == HOLD_TICKS) begin
          next_state = WS_WAIT_HIGH;
        end else if (TC_TICK_IN) begin
          next_hold = hold + 5'h01;
        end
      end
      WS_WAIT_HIGH: begin
        // window restarts on the pin going high
        if (PORT_G_BIT_ONE_IN) begin
          next_cnt = '0;
          next_state = locked ? WS_RUN : WS_INIT;
        end
      end
      default: begin
        next_state = WS_INIT;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Pin, idle timer and register reads
  // ----------------------------------------------------------------------
  always_comb begin
    // pin only ever pulled low, otherwise released
    // either fault source pulls the shared driver
    // clock faults drive while slow plus hold
    next_oe = wd_drive | cm_fault;
    next_idle_cnt = idle_cnt;
    next_pend = pend;
    if (TC_TICK_IN) begin
      next_idle_cnt = idle_cnt + 16'h0001;
    end
    if (WR_IN && ADDR_IN == ADDR_IDLE_TIMER && WDATA_IN[PEND_BIT]) begin
      next_pend = 1'b0;
    end
    // bit twelve toggles, flag set wins over clear
    if (next_idle_cnt[IDLE_TOGGLE_BIT] != idle_cnt[IDLE_TOGGLE_BIT]) begin
      next_pend = 1'b1;
    end
    next_rdata = 8'h00;
    if (RD_IN) begin
      case (ADDR_IN)
        ADDR_SERVICE: begin
          next_rdata[WIN_MSB:WIN_LSB] = win;
          next_rdata[MON_BIT] = mon;
        end
        ADDR_IDLE_TIMER: begin
          next_rdata[PEND_BIT] = pend;
        end
        ADDR_STATUS: begin
          next_rdata[ST_WD_BIT] = wd_drive;
          next_rdata[ST_CLK_BIT] = cm_fault;
          next_rdata[ST_LOCK_BIT] = locked;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Idle counter has no reset on purpose; it only gets a power-up value
  always_ff @(posedge CLOCK_IN) begin
    if (CE_IN) begin
      idle_cnt <= next_idle_cnt;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    // reset arms with full window and monitor on
    if (!NRST_IN) begin
      state <= WS_INIT;
      cnt <= '0;
      win <= WIN_RESET;
      mon <= MON_RESET;
      locked <= 1'b0;
      hold <= '0;
      halt_q <= 1'b0;
      idle_q <= 1'b0;
      pend <= 1'b0;
      oe <= 1'b0;
      rdata <= 8'h00;
    end else if (CE_IN) begin
      state <= next_state;
      cnt <= next_cnt;
      win <= next_win;
      mon <= next_mon;
      locked <= next_locked;
      hold <= next_hold;
      halt_q <= HALT_IN;
      idle_q <= IDLE_IN;
      pend <= next_pend;
      oe <= next_oe;
      rdata <= next_rdata;
    end
  end

  always_comb begin
    RDATA_OUT = rdata;
    PORT_G_BIT_ONE_OE_OUT = oe;
    IDLE_TIMER_PENDING_OUT = pend;
  end

  // Drive level is a constant zero held in a flop
  always_ff @(posedge CLOCK_IN) begin
    PORT_G_BIT_ONE_OUT <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!NRST_IN);

  sequence s_pin_seen_low;
    CE_IN && state == WS_PULL && !PORT_G_BIT_ONE_IN;
  endsequence

  sequence s_hold_done;
    CE_IN && state == WS_HOLD && hold == HOLD_TICKS;
  endsequence

  sequence s_early_service;
    CE_IN && state == WS_RUN && svc_wr && cnt < LOWER_TICKS;
  endsequence

  a_reset_arms: assert property (
    $rose(NRST_IN) |-> state == WS_INIT && win == 2'h3 && mon && !oe)
    else $error("watchdog not armed with full window after reset");

  a_early_fault: assert property (
    s_early_service |=> state == WS_PULL ##1 oe)
    else $error("early service did not raise a fault");

  a_timeout_bound: assert property (
    state == WS_RUN |-> cnt <= upper_ticks(win))
    else $error("window count passed its upper limit");

  a_hold_entry: assert property (
    s_pin_seen_low |=> state == WS_HOLD && hold == 5'h00 && oe)
    else $error("hold did not start when pin went low");

  a_hold_release: assert property (
    s_hold_done |=> state == WS_WAIT_HIGH ##1 (oe == $past(cm_fault)))
    else $error("pin not released after hold");

  a_restart_high: assert property (
    CE_IN && state == WS_WAIT_HIGH && PORT_G_BIT_ONE_IN
      |=> cnt == 17'h00000 && state != WS_WAIT_HIGH)
    else $error("window not restarted on pin high");

  a_first_write: assert property (
    CE_IN && state == WS_INIT && svc_wr && key_ok
      |=> locked && cnt == 17'h00000 && state == WS_RUN)
    else $error("first keyed write did not lock and restart");

  a_fault_ignore: assert property (
    CE_IN && wd_drive && svc_wr
      |=> $stable(cnt) && $stable(win) && $stable(mon))
    else $error("service accepted during fault output");

  a_key_hidden: assert property (
    CE_IN && RD_IN && ADDR_IN == ADDR_SERVICE |=> RDATA_OUT[5:1] == 5'h00)
    else $error("key field visible on read");

  a_idle_freeze: assert property (
    CE_IN && (IDLE_IN || HALT_IN) && !halt_exit && !idle_exit
      && state == WS_RUN && !svc_wr && cnt < upper |=> $stable(cnt))
    else $error("watchdog counted during halt or idle");

  a_idle_service: assert property (
    CE_IN && idle_exit && state == WS_RUN && !svc_wr && !HALT_IN
      |=> cnt == 17'h00000)
    else $error("idle exit did not service the watchdog");

  a_pend_set: assert property (
    CE_IN && TC_TICK_IN && idle_cnt[11:0] == 12'hfff
      |=> IDLE_TIMER_PENDING_OUT)
    else $error("idle flag not set on bit twelve toggle");

  a_shared_pin: assert property (
    CE_IN && (cm_fault || wd_drive) |=> PORT_G_BIT_ONE_OE_OUT)
    else $error("fault source did not pull the pin");
endmodule
`default_nettype wire

// [pkg/wwd_pkg.sv]
// Constants, register map and state type for the windowed watchdog block
package wwd_pkg;
  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  // Longest instruction-cycle gap still taken as a running clock
  localparam int MON_LIMIT_NS = 1_000_000;
  localparam int MON_LIMIT_CYC = MON_LIMIT_NS / CLK_PERIOD_NS;
  localparam logic [16:0] LOWER_TICKS = 17'h00800;
  localparam logic [16:0] UPPER_BASE_TICKS = 17'h02000;
  localparam logic [4:0] HOLD_TICKS = 5'h18;
  localparam int IDLE_TOGGLE_BIT = 12;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_SERVICE = 8'h00;
  localparam logic [7:0] ADDR_IDLE_TIMER = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam int WIN_MSB = 7;
  localparam int WIN_LSB = 6;
  localparam int KEY_MSB = 5;
  localparam int KEY_LSB = 1;
  localparam int MON_BIT = 0;
  localparam logic [4:0] SERVICE_KEY = 5'h0c;
  localparam logic [1:0] WIN_RESET = 2'h3;
  localparam logic MON_RESET = 1'b1;
  localparam int PEND_BIT = 0;
  localparam int ST_WD_BIT = 0;
  localparam int ST_CLK_BIT = 1;
  localparam int ST_LOCK_BIT = 2;
  // ----------------------------------------------------------------------
  // Watchdog states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    WS_INIT = 3'b000,
    WS_RUN = 3'b001,
    WS_PULL = 3'b010,
    WS_HOLD = 3'b011,
    WS_WAIT_HIGH = 3'b100
  } wwd_state_t;
endpackage

// [logic/wwd_clock_monitor.sv]
// Instruction-cycle rate monitor with release hold after recovery
`timescale 1ns/1ns
`default_nettype none
module wwd_clock_monitor #(
  parameter int LIMIT_CYC = 250000,
  parameter logic [4:0] HOLD = 5'h18
) (
  input wire logic clock_in, // System clock
  input wire logic nrst_in, // Synchronous reset, active low
  input wire logic ce_in, // Clock enable
  input wire logic enable_in, // Monitor selected
  input wire logic tick_in, // One instruction cycle
  output logic fault_out // Rate too low or still holding
);
  import wwd_pkg::*;
  localparam int CW = $clog2(LIMIT_CYC + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT_CYC);

  logic [CW-1:0] gap, next_gap;
  logic slow, next_slow;
  logic [4:0] hold, next_hold;
  logic next_fault;

  // ----------------------------------------------------------------------
  // Gap measurement
  // ----------------------------------------------------------------------
  always_comb begin
    next_gap = gap;
    next_slow = slow;
    next_hold = hold;
    if (!enable_in) begin
      next_gap = '0;
      next_slow = 1'b0;
      next_hold = '0;
    end else if (tick_in) begin
      next_gap = '0;
      // One short gap counts as recovery; the hold covers jitter
      if (slow) begin
        next_slow = 1'b0;
        next_hold = HOLD;
      end else if (hold != '0) begin
        next_hold = hold - 5'h01;
      end
    end else if (gap == LIM) begin
      next_slow = 1'b1;
    end else begin
      next_gap = gap + {{(CW-1){1'b0}}, 1'b1};
    end
    next_fault = next_slow | (next_hold != '0);
  end

  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      gap <= '0;
      slow <= 1'b0;
      hold <= '0;
      fault_out <= 1'b0;
    end else if (ce_in) begin
      gap <= next_gap;
      slow <= next_slow;
      hold <= next_hold;
      fault_out <= next_fault;
    end
  end
endmodule
`default_nettype wire

// [verification/wwd_pin_model.sv]
// Pull-up and sensing model of the shared open-drain fault pin
`timescale 1ns/1ns
`default_nettype none
module wwd_pin_model (
  input wire logic clk_in, // System clock
  input wire logic oe_in, // Device pulls the pin
  input wire logic drv_in, // Device drive level
  input wire logic [3:0] lag_in, // Cycles the line takes to fall
  output logic pin_out // Sensed pin level
);
  logic [3:0] cnt = 4'h0;
  // ----------------------------------------------------------------
  // Line fall time
  // ----------------------------------------------------------------
  // Load capacitance: a slow line lets hold timing start late
  always @(posedge clk_in) begin
    if (!oe_in)
      cnt <= 4'h0;
    else if (cnt != lag_in)
      cnt <= cnt + 4'h1;
  end
  assign pin_out = ~(oe_in && cnt == lag_in && !drv_in);
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the windowed watchdog with clock monitor
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import wwd_pkg::*;
  typedef struct {logic [7:0] d; int gap; logic f;} wwd_row_t;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic tick = 1'b1;
  logic halt = 1'b0;
  logic idle = 1'b0;
  logic rc = 1'b0;
  logic sdly = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [3:0] lag = 4'h0;
  logic [7:0] rdata;
  logic pin, pout, poe, pend;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  wwd_row_t rows [6];
  logic [2:0] hopt [3];

  always #2 clk = ~clk;

  // Short monitor limit keeps the slow-clock case brief
  wwd_top #(.MON_LIMIT(200)) dut (
    .CLOCK_IN(clk),
    .NRST_IN(nrst),
    .CE_IN(1'b1),
    .TC_TICK_IN(tick),
    .HALT_IN(halt),
    .IDLE_IN(idle),
    .RC_OPTION_IN(rc),
    .OSCILLATOR_START_DELAY_IN(sdly),
    .PORT_G_BIT_ONE_IN(pin),
    .ADDR_IN(addr),
    .WDATA_IN(wdata),
    .WR_IN(wr),
    .RD_IN(rd),
    .RDATA_OUT(rdata),
    .PORT_G_BIT_ONE_OUT(pout),
    .PORT_G_BIT_ONE_OE_OUT(poe),
    .IDLE_TIMER_PENDING_OUT(pend)
  );

  wwd_pin_model pm (
    .clk_in(clk),
    .oe_in(poe),
    .drv_in(pout),
    .lag_in(lag),
    .pin_out(pin)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic do_reset(input int n);
    nrst <= 1'b0;
    wait_cyc(n);
    nrst <= 1'b1;
    @(posedge clk);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask

  task automatic chk_oe(input logic e);
    #1;
    chk({7'h0, poe}, {7'h0, e});
    chk({7'h0, pout}, 8'h00);
    @(posedge clk);
  endtask

  // Hold time is counted from the moment the line is seen low
  task automatic recover();
    int n = 0;
    #1;
    while (pin !== 1'b0 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    while (poe === 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(n >= 16 && n <= 34), 8'h01);
    @(posedge clk);
  endtask

  task automatic watch(input int lim, input logic want);
    int n = 0;
    #1;
    while (poe !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h0, poe}, {7'h0, want});
    @(posedge clk);
    if (poe === 1'b1)
      recover();
  endtask

  task automatic wait_pend(output int n);
    n = 0;
    #1;
    while (pend !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    int k;
    rows = '{'{8'h19, 2060, 1'b0}, '{8'h59, 2060, 1'b1},
             '{8'h1b, 2060, 1'b1}, '{8'h18, 2060, 1'b1},
             '{8'h19, 2030, 1'b1}, '{8'h19, 2060, 1'b0}};
    hopt = '{3'b001, 3'b100, 3'b111};
    do_reset(16);
    chk_oe(1'b0);
    rd_reg(ADDR_SERVICE, d);
    chk(d, 8'hc1);
    lag <= 4'h9;
    wr_reg(ADDR_SERVICE, 8'h1b);
    watch(6, 1'b1);
    lag <= 4'h0;
    wr_reg(ADDR_SERVICE, 8'h58);
    watch(6, 1'b0);
    rd_reg(ADDR_SERVICE, d);
    chk(d, 8'h40);
    rd_reg(ADDR_STATUS, d);
    chk(d, 8'(1 << ST_LOCK_BIT));
    tick <= 1'b0;
    wait_cyc(300);
    chk_oe(1'b0);
    do_reset(300);
    chk_oe(1'b0);
    tick <= 1'b1;
    $display("first write tests done");
    wr_reg(ADDR_SERVICE, 8'h19);
    watch(6, 1'b0);
    foreach (rows[i]) begin
      wait_cyc(rows[i].gap);
      wr_reg(ADDR_SERVICE, rows[i].d);
      watch(6, rows[i].f);
      $display("row %0d done", i);
    end
    // Second write lands while the pin is already pulled
    wr_reg(ADDR_SERVICE, 8'h19);
    wr_reg(ADDR_SERVICE, 8'h19);
    watch(6, 1'b1);
    watch(100, 1'b0);
    $display("ignored service test done");
    wait_cyc(4200);
    idle <= 1'b1;
    // Flag is long stale here; clear it and sync to a fresh toggle first
    wr_reg(ADDR_IDLE_TIMER, 8'h01);
    wait_pend(k);
    wr_reg(ADDR_IDLE_TIMER, 8'h01);
    #1;
    chk({7'h0, pend}, 8'h00);
    wait_pend(k);
    chk(8'(k + 3 == 4096), 8'h01);
    rd_reg(ADDR_IDLE_TIMER, d);
    chk({7'h0, d[0]}, 8'h01);
    chk_oe(1'b0);
    idle <= 1'b0;
    wait_cyc(1000);
    wr_reg(ADDR_SERVICE, 8'h19);
    watch(6, 1'b1);
    $display("idle test done");
    for (int i = 0; i < 3; i++) begin
      rc <= hopt[i][2];
      sdly <= hopt[i][1];
      wait_cyc(2100);
      halt <= 1'b1;
      wait_cyc(50);
      halt <= 1'b0;
      wait_cyc(20);
      wr_reg(ADDR_SERVICE, 8'h19);
      watch(6, hopt[i][0]);
    end
    $display("halt tests done");
    halt <= 1'b1;
    tick <= 1'b0;
    wait_cyc(260);
    chk_oe(1'b1);
    wait_cyc(100);
    chk_oe(1'b1);
    rd_reg(ADDR_STATUS, d);
    chk(d, 8'(1 << ST_CLK_BIT | 1 << ST_LOCK_BIT));
    tick <= 1'b1;
    recover();
    halt <= 1'b0;
    $display("clock monitor test done");
    for (int w = 0; w < 3; w++) begin
      do_reset(2);
      wait_cyc(300);
      wr_reg(ADDR_SERVICE, {2'(w), 5'h0c, 1'b1});
      wait_cyc((8192 << w) - 120);
      chk_oe(1'b0);
      watch(150, 1'b1);
      $display("window %0d test done", w);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
